// ==== bench/rce_mem_model.sv ====
// Program and data memory model on the far side of the execution core
`timescale 1ns/1ps
module rce_mem_model (
	// Fetch side
	input  wire logic          i_sys_clk,
	input  wire logic [31:0]   i_fetch_addr,
	output logic [15:0]        o_fetch_instr,
	output logic               o_fetch_valid,
	// Data side
	input  wire logic          i_dmem_req,
	input  wire logic          i_dmem_we,
	input  wire logic [31:0]   i_dmem_addr,
	input  rce_pkg::rce_size_t i_dmem_size,
	input  wire logic [31:0]   i_dmem_wdata,
	output logic               o_dmem_ack,
	output logic [31:0]        o_dmem_rdata
);
	import rce_pkg::*;
	logic [7:0] mem [0:4095];
	integer     seed     = 32'hfdaa12d5;
	int         wait_cnt = 0;
	logic [11:0] b;
	// Big-endian byte memory, right-justified read data
	function automatic logic [31:0] rd(input logic [11:0] a, input rce_size_t s);
		case (s)
			SZ_BYTE: rd = {24'h0, mem[a]};
			SZ_WORD: rd = {16'h0, mem[a], mem[a+12'h1]};
			default: rd = {mem[a], mem[a+12'h1], mem[a+12'h2], mem[a+12'h3]};
		endcase
	endfunction : rd
	// One 16-bit instruction per fetch; scrambled while not valid
	always_comb begin
		b             = i_fetch_addr[11:0];
		o_fetch_instr = {mem[b], mem[b+12'h1]};
		if (!o_fetch_valid) o_fetch_instr = ~o_fetch_instr;
	end
	initial begin
		o_fetch_valid = 1'b0;
		o_dmem_ack    = 1'b0;
		o_dmem_rdata  = 32'h0;
	end
	// Random fetch stalls and ack waits; data scrambled outside ack
	always @(posedge i_sys_clk) begin
		o_fetch_valid <= (($random(seed) & 3) != 0);
		o_dmem_ack    <= 1'b0;
		o_dmem_rdata  <= ~o_dmem_rdata;
		if (i_dmem_req && !o_dmem_ack) begin
			if (wait_cnt == 0) begin
				o_dmem_ack <= 1'b1;
				wait_cnt   <= $random(seed) & 3;
				if (!i_dmem_we) o_dmem_rdata <= rd(i_dmem_addr[11:0], i_dmem_size);
				else begin
					case (i_dmem_size)
						SZ_BYTE: mem[i_dmem_addr[11:0]] = i_dmem_wdata[7:0];
						SZ_WORD: {mem[i_dmem_addr[11:0]], mem[i_dmem_addr[11:0]+12'h1]} = i_dmem_wdata[15:0];
						default: for (int k = 0; k < 4; k++)
							mem[i_dmem_addr[11:0]+k] = i_dmem_wdata[31-8*k -: 8];
					endcase
				end
			end else wait_cnt <= wait_cnt - 1;
		end
	end
endmodule : rce_mem_model

// ==== bench/tb_risc_cpu_core_register_and_exec.sv ====
// Self-checking bench running a small program through the execution core
`timescale 1ns/1ps
module tb_risc_cpu_core_register_and_exec;
	import rce_pkg::*;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} rce_note_t;
	logic        i_sys_clk;
	logic        i_reset;
	logic [31:0] o_fetch_addr;
	logic [15:0] i_fetch_instr;
	logic        i_fetch_valid;
	logic        o_dmem_req;
	logic        o_dmem_we;
	logic [31:0] o_dmem_addr;
	rce_size_t   o_dmem_size;
	logic [31:0] o_dmem_wdata;
	logic        i_dmem_ack;
	logic [31:0] i_dmem_rdata;
	logic        o_retire;
	logic        o_addr_error;
	int          err_total = 0;
	int          checks    = 0;
	int          cycles    = 0;
	int          ae_cnt    = 0;
	int          rt_cnt    = 0;
	int          rt_end    = 0;
	rce_note_t   notes[$];
	rce_note_t   nt;
	// Program at reset entry, then the address-error handler
	logic [15:0] prog_a [0:10] = '{16'h0240, 16'h0180, 16'h8129, 16'h00ff, 16'h300f, 16'h8029,
		16'h0360, 16'h8430, 16'h8429, 16'h0541, 16'h8159};
	logic [15:0] prog_b [0:34] = '{16'h220f, 16'h1001, 16'hc001, 16'h0055, 16'h0055, 16'h8029,
		16'hb002, 16'h1001, 16'h0066, 16'h0066, 16'h8029, 16'h06fd, 16'h0705, 16'h7677,
		16'h780b, 16'h8829, 16'hd001, 16'h0900, 16'h0000, 16'h7a0c, 16'h8a29, 16'h700e,
		16'h7679, 16'h7678, 16'h7b0a, 16'h7c0b, 16'h8b29, 16'h8c29, 16'had10, 16'h8d29,
		16'h9e08, 16'h8e29, 16'hbffe, 16'h0000, 16'h0000};
	rce_core uut (
		.i_sys_clk    (i_sys_clk),
		.i_reset      (i_reset),
		.o_fetch_addr (o_fetch_addr),
		.i_fetch_instr(i_fetch_instr),
		.i_fetch_valid(i_fetch_valid),
		.o_dmem_req   (o_dmem_req),
		.o_dmem_we    (o_dmem_we),
		.o_dmem_addr  (o_dmem_addr),
		.o_dmem_size  (o_dmem_size),
		.o_dmem_wdata (o_dmem_wdata),
		.i_dmem_ack   (i_dmem_ack),
		.i_dmem_rdata (i_dmem_rdata),
		.o_retire     (o_retire),
		.o_addr_error (o_addr_error)
	);
	rce_mem_model mem (
		.i_sys_clk    (i_sys_clk),
		.i_fetch_addr (o_fetch_addr),
		.o_fetch_instr(i_fetch_instr),
		.o_fetch_valid(i_fetch_valid),
		.i_dmem_req   (o_dmem_req),
		.i_dmem_we    (o_dmem_we),
		.i_dmem_addr  (o_dmem_addr),
		.i_dmem_size  (o_dmem_size),
		.i_dmem_wdata (o_dmem_wdata),
		.o_dmem_ack   (i_dmem_ack),
		.o_dmem_rdata (i_dmem_rdata)
	);
	// Compare one value and count it
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic poke32(input int a, input logic [31:0] v);
		for (int k = 0; k < 4; k++) mem.mem[a+k] = v[31-8*k -: 8];
	endtask : poke32
	// Counts, verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	// System clock, 50 ns period
	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	// Watch stores: oldest note against each completed write
	always @(posedge i_sys_clk) begin
		if (!i_reset && o_dmem_req === 1'b1 && i_dmem_ack && o_dmem_we === 1'b1) begin
			if (notes.size() == 0) check("unexpected_store", 32'h0, 32'h1);
			else begin
				nt = notes.pop_front();
				check("store_addr", nt.addr, o_dmem_addr);
				check("store_size", {30'h0, SZ_LONG}, {30'h0, o_dmem_size});
				check("store_data", nt.data, o_dmem_wdata);
				$display("test store at %h done", nt.addr);
				if (notes.size() == 0) rt_end = rt_cnt;
			end
		end
		if (o_addr_error === 1'b1) ae_cnt++;
		if (o_retire === 1'b1) rt_cnt++;
	end
	// Hang guard
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 8000) begin
			err_total++;
			$display("CHECK FAILED timeout expected 0 seen %0d", notes.size());
			test_done();
		end
	end
	// Load memory, note expectations, release reset, wait for all stores
	initial begin
		i_reset = 1'b1;
		for (int k = 0; k < 4096; k++) mem.mem[k] = 8'h00;
		poke32(32'h0, 32'h00000100);
		poke32(32'h4, 32'h00001000);
		poke32(32'h24, 32'h00000200);
		poke32(32'h27c, 32'h5a5a1234);
		poke32(32'h250, 32'h80010000);
		mem.mem[32'h60] = 8'h85;
		for (int k = 0; k < 11; k++) {mem.mem[32'h100+2*k], mem.mem[32'h101+2*k]} = prog_a[k];
		for (int k = 0; k < 35; k++) {mem.mem[32'h200+2*k], mem.mem[32'h201+2*k]} = prog_b[k];
		notes.push_back('{32'h40, 32'hffffff80});
		notes.push_back('{32'h40, 32'h0000000f});
		notes.push_back('{32'h40, 32'hffffff85});
		notes.push_back('{32'hffc, 32'h000000f0});
		notes.push_back('{32'hff8, 32'h00000114});
		notes.push_back('{32'h40, 32'h00000010});
		notes.push_back('{32'h40, 32'h00000011});
		notes.push_back('{32'h40, 32'hfffffff1});
		notes.push_back('{32'h40, 32'h00000224});
		notes.push_back('{32'h40, 32'hffffffff});
		notes.push_back('{32'h40, 32'hffffffe2});
		notes.push_back('{32'h40, 32'h5a5a1234});
		notes.push_back('{32'h40, 32'hffff8001});
		repeat (2) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		for (int k = 0; k < 6000 && notes.size() != 0; k++) @(posedge i_sys_clk);
		repeat (20) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		check("notes_left", 32'h0, notes.size());
		check("addr_error_pulses", 32'h1, ae_cnt);
		check("retire_count", 32'h26, rt_end);
		check("loop_pc", 32'h1, {31'h0, (o_fetch_addr === 32'h240) || (o_fetch_addr === 32'h242)});
		$display("test program run done");
		test_done();
	end
endmodule : tb_risc_cpu_core_register_and_exec

// ==== verilog/rce_core.sv ====
// 32-bit execution core with 16-bit instructions, system registers and data access
`timescale 1ns/1ps
`include "rce_map.svh"
// Function
// [RQ1] Four 32-bit system registers exist
// [RQ2] MAC pair takes products; calls save return
// [RQ3] R15 loaded from vector table at reset
// [RQ4] Interrupt mask set, reserved bits cleared
// [RQ5] Program counter loaded from vector table
// [RQ6] Vector base cleared at reset
// [RQ7] Byte and word loads sign-extended
// [RQ8] Misaligned word or longword gives address error
// [RQ9] Stack accessed only as aligned longwords
// [RQ10] Move, add, compare immediates sign-extended
// [RQ11] Logic and test immediates zero-extended
// [RQ12] Wide constants loaded PC-relative from memory
// [RQ13] Only fixed 16-bit instructions decoded
// [RQ14] Basic instructions take one cycle
// [RQ15] Unconditional branches delayed; conditional both forms
// [RQ16] 16x16 multiply in one to two cycles
// [RQ17] 16x16 plus 64 accumulate in two-three cycles
// [RQ18] 32x32 accumulate in two to four cycles
// [RQ19] Compares write flag; branches test it
// [RQ20] Add leaves condition flag alone
// [RQ21] Register operations; bit logic on memory
// [RQ22] Exceptions push status and PC via R15
module rce_core (
	// Clock and reset
	input  wire logic          i_sys_clk,
	input  wire logic          i_reset,
	// Instruction fetch
	output logic [31:0]        o_fetch_addr,
	input  wire logic [15:0]   i_fetch_instr,
	input  wire logic          i_fetch_valid,
	// Data access
	output logic               o_dmem_req,
	output logic               o_dmem_we,
	output logic [31:0]        o_dmem_addr,
	output rce_pkg::rce_size_t o_dmem_size,
	output logic [31:0]        o_dmem_wdata,
	input  wire logic          i_dmem_ack,
	input  wire logic [31:0]   i_dmem_rdata,
	// Status
	output logic               o_retire,
	output logic               o_addr_error
);
	import rce_pkg::*;
	localparam int INSTR_CYC = `RCE_INSTR_CYC;

	rce_core_st_t s, n;
	logic        exec;
	rce_op_t     dec_op;
	rce_func_t   dec_fn;
	logic [3:0]  dec_rn;
	logic [3:0]  dec_rm;
	rce_size_t   dec_sz;
	logic [31:0] dec_sx;
	logic [31:0] dec_zx;
	logic [31:0] r_n;
	logic [31:0] r_m;
	logic [31:0] seq_pc;
	logic [31:0] pc4;
	logic [31:0] sp_dec;
	logic [31:0] ld_ext;
	logic [7:0]  rmw_byte;
	logic        compare_equal_instr_i;
	logic        br_take;
	logic        mac_start;
	rce_macop_t  mac_op_c;
	logic        mac_done;
	logic [63:0] mac_res;

	// Misaligned word or longword address
	function automatic logic misal(input logic [31:0] a, input rce_size_t z);
		misal = ((z == SZ_WORD) && a[0]) || ((z == SZ_LONG) && (a[1:0] != 2'h0));
	endfunction : misal

	// Field decode of the 16-bit instruction
	assign exec     = (s.st == ST_RUN) && i_fetch_valid;                         // RQ13
	assign dec_op   = rce_op_t'(i_fetch_instr[15:12]);                           // RQ13
	assign dec_fn   = rce_func_t'(i_fetch_instr[3:0]);
	assign dec_rn   = i_fetch_instr[11:8];
	assign dec_rm   = i_fetch_instr[7:4];
	assign dec_sz   = rce_size_t'(i_fetch_instr[3:2]);
	assign dec_sx   = {{24{i_fetch_instr[7]}}, i_fetch_instr[7:0]};              // RQ10
	assign dec_zx   = {24'h0, i_fetch_instr[7:0]};                               // RQ11
	assign r_n      = s.gpr[dec_rn];
	assign r_m      = s.gpr[dec_rm];
	assign pc4      = s.pc + `RCE_INSTR_BYTES + `RCE_INSTR_BYTES;
	assign seq_pc   = s.br_pend ? s.br_tgt : (s.pc + `RCE_INSTR_BYTES);         // RQ15
	assign sp_dec   = {s.gpr[15][31:2], 2'h0} - `RCE_SLOT_BYTES;                 // RQ9
	assign compare_equal_instr_i = (s.gpr[0] == dec_sx);
	assign br_take  = (s.sr[`RCE_SR_T_BIT] == ~i_fetch_instr[10]);               // RQ19

	// Load data sign extension by access size
	always_comb begin
		case (s.size)
			SZ_BYTE: ld_ext = {{24{i_dmem_rdata[7]}}, i_dmem_rdata[7:0]};        // RQ7
			SZ_WORD: ld_ext = {{16{i_dmem_rdata[15]}}, i_dmem_rdata[15:0]};      // RQ7
			default: ld_ext = i_dmem_rdata;
		endcase
	end

	// Bit logic result for memory operand
	always_comb begin
		case (s.rmw_op)
			2'h0:    rmw_byte = i_dmem_rdata[7:0] & s.rmw_imm;                   // RQ21
			2'h1:    rmw_byte = i_dmem_rdata[7:0] | s.rmw_imm;
			default: rmw_byte = i_dmem_rdata[7:0] ^ s.rmw_imm;
		endcase
	end

	// Multiplier start and mode from the decoded function
	always_comb begin
		mac_start = exec && (dec_op == OP_REG) &&
			((dec_fn == FN_MUL16) || (dec_fn == FN_MAC16) || (dec_fn == FN_MAC32));
		case (dec_fn)
			FN_MUL16: mac_op_c = MAC_MUL16;
			FN_MAC16: mac_op_c = MAC_ACC16;
			default:  mac_op_c = MAC_ACC32;
		endcase
	end

	// Multiplier and accumulator
	rce_mac_unit u_mac (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_start   (mac_start),
		.i_op      (mac_op_c),
		.i_a       (r_n),
		.i_b       (r_m),
		.i_acc     ({s.mac_result_high, s.mac_result_low}),
		.o_done    (mac_done),
		.o_result  (mac_res)
	);

	// Next state of the whole core
	always_comb begin
		n = s;
		n.addr_err = 1'b0;
		n.retire = 1'b0;
		case (s.st)
			ST_VEC_PC, ST_VEC_SP, ST_EXC_VEC: begin
				if (!s.req) begin
					n.req = 1'b1;
					n.we = 1'b0;
					n.size = SZ_LONG;
					n.addr = s.vector_base_reg + ((s.st == ST_VEC_SP) ? `RCE_VEC_SP_OFS :
						((s.st == ST_VEC_PC) ? `RCE_VEC_PC_OFS : `RCE_VEC_ADDRERR_OFS));
				end else if (i_dmem_ack) begin
					n.req = 1'b0;
					if (s.st == ST_VEC_SP) begin
						n.gpr[15] = i_dmem_rdata;                                     // RQ3
						n.st = ST_RUN;
					end else begin
						n.pc = i_dmem_rdata;                                          // RQ5
						n.st = (s.st == ST_VEC_PC) ? ST_VEC_SP : ST_RUN;
					end
				end
			end
			ST_RUN: begin
				if (exec) begin
					n.retire = 1'b1;
					n.pc = seq_pc;                                                    // RQ14
					n.br_pend = 1'b0;
					case (dec_op)
						OP_MOVI:   n.gpr[dec_rn] = dec_sx;                            // RQ10
						OP_ADDI:   n.gpr[dec_rn] = r_n + dec_sx;                      // RQ20
						OP_CMPEQI: n.sr[`RCE_SR_T_BIT] = compare_equal_instr_i;                    // RQ19
						OP_ANDI:   n.gpr[0] = s.gpr[0] & dec_zx;                      // RQ11
						OP_ORI:    n.gpr[0] = s.gpr[0] | dec_zx;
						OP_XORI:   n.gpr[0] = s.gpr[0] ^ dec_zx;
						OP_TSTI:   n.sr[`RCE_SR_T_BIT] = ((s.gpr[0] & dec_zx) == 32'h0);
						OP_REG: begin
							case (dec_fn)
								FN_MOV:    n.gpr[dec_rn] = r_m;
								FN_ADD:    n.gpr[dec_rn] = r_n + r_m;                 // RQ21
								FN_AND:    n.gpr[dec_rn] = r_n & r_m;
								FN_OR:     n.gpr[dec_rn] = r_n | r_m;
								FN_XOR:    n.gpr[dec_rn] = r_n ^ r_m;
								FN_CMPEQ:  n.sr[`RCE_SR_T_BIT] = (r_n == r_m);        // RQ19
								FN_CMPGE:  n.sr[`RCE_SR_T_BIT] = ($signed(r_n) >= $signed(r_m));
								FN_MUL16, FN_MAC16, FN_MAC32: n.st = ST_MAC;          // RQ2
								FN_STS_HI: n.gpr[dec_rn] = s.mac_result_high;                    // RQ1
								FN_STS_LO: n.gpr[dec_rn] = s.mac_result_low;
								FN_STS_PR: n.gpr[dec_rn] = s.pr;
								FN_LDC_GB: n.global_base_reg = r_n;
								FN_CLRMAC: begin
									n.mac_result_high = 32'h0;
									n.mac_result_low = 32'h0;
								end
								default:   n.gpr[dec_rn] = s.sr;
							endcase
						end
						OP_LDST: begin
							if (misal(r_m, dec_sz)) begin
								n.addr_err = 1'b1;                                    // RQ8
								n.exc_pc = s.pc;
								n.pc = s.pc;
								n.st = ST_PUSH_SR;
							end else begin
								n.req = 1'b1;
								n.we = i_fetch_instr[0];
								n.addr = r_m;
								n.size = dec_sz;
								n.wdata = r_n;
								n.ld_rn = dec_rn;
								n.rmw = 1'b0;
								n.st = ST_MEM;
							end
						end
						OP_LDPCW, OP_LDPCL: begin
							n.req = 1'b1;                                             // RQ12
							n.we = 1'b0;
							n.rmw = 1'b0;
							n.ld_rn = dec_rn;
							n.size = (dec_op == OP_LDPCW) ? SZ_WORD : SZ_LONG;
							n.addr = (dec_op == OP_LDPCW) ? (pc4 + {23'h0, i_fetch_instr[7:0], 1'b0}) :
								({pc4[31:2], 2'h0} + {22'h0, i_fetch_instr[7:0], 2'h0});
							n.st = ST_MEM;
						end
						OP_BRA, OP_BSR: begin
							n.br_pend = 1'b1;                                         // RQ15
							n.br_tgt = pc4 + {{19{i_fetch_instr[11]}}, i_fetch_instr[11:0], 1'b0};
							if (dec_op == OP_BSR) begin
								n.pr = pc4;                                           // RQ2
							end
						end
						OP_RTS: begin
							n.br_pend = 1'b1;
							n.br_tgt = s.pr;
						end
						OP_BCOND: begin
							if (br_take && i_fetch_instr[11]) begin
								n.br_pend = 1'b1;                                     // RQ15
								n.br_tgt = pc4 + {{23{i_fetch_instr[7]}}, i_fetch_instr[7:0], 1'b0};
							end else if (br_take) begin
								n.pc = pc4 + {{23{i_fetch_instr[7]}}, i_fetch_instr[7:0], 1'b0};
							end
						end
						default: begin
							n.req = 1'b1;                                             // RQ21
							n.we = 1'b0;
							n.addr = s.global_base_reg + s.gpr[0];
							n.size = SZ_BYTE;
							n.rmw = 1'b1;
							n.rmw_op = i_fetch_instr[9:8];
							n.rmw_imm = i_fetch_instr[7:0];
							n.st = ST_MEM;
						end
					endcase
				end
			end
			ST_MEM: begin
				if (i_dmem_ack) begin
					n.req = 1'b0;
					n.st = ST_RUN;
					if (!s.we && s.rmw) begin
						n.req = 1'b1;                                                 // RQ21
						n.we = 1'b1;
						n.wdata = {24'h0, rmw_byte};
						n.st = ST_RMW_WR;
					end else if (!s.we) begin
						n.gpr[s.ld_rn] = ld_ext;                                      // RQ7
					end
				end
			end
			ST_RMW_WR: begin
				if (i_dmem_ack) begin
					n.req = 1'b0;
					n.rmw = 1'b0;
					n.st = ST_RUN;
				end
			end
			ST_MAC: begin
				if (mac_done) begin
					n.mac_result_high = mac_res[63:32];                                          // RQ2
					n.mac_result_low = mac_res[31:0];
					n.st = ST_RUN;
				end
			end
			ST_PUSH_SR, ST_PUSH_PC: begin
				if (!s.req) begin
					n.req = 1'b1;                                                     // RQ22
					n.we = 1'b1;
					n.size = SZ_LONG;                                                 // RQ9
					n.addr = sp_dec;
					n.wdata = (s.st == ST_PUSH_SR) ? s.sr : s.exc_pc;
				end else if (i_dmem_ack) begin
					n.req = 1'b0;
					n.gpr[15] = sp_dec;                                               // RQ22
					n.st = (s.st == ST_PUSH_SR) ? ST_PUSH_PC : ST_EXC_VEC;
				end
			end
			default: n.st = ST_VEC_PC;
		endcase
	end

	// State register with reset values
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			s <= '0;
			s.sr <= `RCE_SR_RESET;                                                   // RQ4
			s.vector_base_reg <= `RCE_VBR_RESET;                                                 // RQ6
		end else begin
			s <= n;
		end
	end

	// Port drive from state flops
	assign o_fetch_addr = s.pc;
	assign o_dmem_req   = s.req;
	assign o_dmem_we    = s.we;
	assign o_dmem_addr  = s.addr;
	assign o_dmem_size  = s.size;
	assign o_dmem_wdata = s.wdata;
	assign o_retire     = s.retire;
	assign o_addr_error = s.addr_err;

	// Checks on core behaviour
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	sequence bra_seen;
		exec && (dec_op == OP_BRA);
	endsequence
	sequence slot_run;
		exec && !mac_start && (dec_op != OP_LDST);
	endsequence

	a_reset_values: assert property ($past(i_reset) |->                           // RQ4
		(s.sr == `RCE_SR_RESET) && (s.vector_base_reg == `RCE_VBR_RESET) && (s.st == ST_VEC_PC))
		else $error("reset status or vector base wrong");
	a_vector_sp: assert property ((s.st == ST_VEC_SP) && s.req && i_dmem_ack |=>  // RQ3
		(s.gpr[15] == $past(i_dmem_rdata)) && (s.st == ST_RUN))
		else $error("stack pointer not taken from vector table");
	a_vector_pc: assert property ((s.st == ST_VEC_PC) && s.req && i_dmem_ack |=>  // RQ5
		(s.pc == $past(i_dmem_rdata)) && (s.st == ST_VEC_SP))
		else $error("program counter not taken from vector table");
	a_align_check: assert property (o_dmem_req |-> !misal(o_dmem_addr, o_dmem_size)) // RQ8
		else $error("misaligned data access issued");
	a_stack_long: assert property (((s.st == ST_PUSH_SR) || (s.st == ST_PUSH_PC)) && o_dmem_req |-> // RQ9
		(o_dmem_size == SZ_LONG) && (o_dmem_addr[1:0] == 2'h0) && o_dmem_we)
		else $error("stack push not an aligned longword");
	a_imm_sext: assert property (exec && (dec_op == OP_MOVI) |=>                  // RQ10
		s.gpr[$past(dec_rn)] == $past(dec_sx))
		else $error("move immediate not sign-extended");
	a_andi_upper: assert property (exec && (dec_op == OP_ANDI) |=> s.gpr[0][31:8] == 24'h0) // RQ11
		else $error("and immediate left upper bits set");
	a_add_keeps_t: assert property (exec && (dec_op == OP_ADDI) |=> $stable(s.sr)) // RQ20
		else $error("add changed the status register");
	a_cmp_sets_t: assert property (exec && (dec_op == OP_CMPEQI) |=>              // RQ19
		s.sr[`RCE_SR_T_BIT] == $past(compare_equal_instr_i))
		else $error("compare result not in condition flag");
	a_bra_delay: assert property (bra_seen ##1 slot_run |=>                        // RQ15
		(s.pc == $past(s.br_tgt)) && !s.br_pend)
		else $error("branch did not follow its delay slot");
	a_one_cycle: assert property (exec && (dec_op == OP_MOVI) && !s.br_pend |->   // RQ14
		##INSTR_CYC (s.st == ST_RUN) && (s.pc == $past(s.pc) + `RCE_INSTR_BYTES))
		else $error("basic instruction took more than one cycle");
	a_mul16_time: assert property (mac_start && (mac_op_c == MAC_MUL16) |->       // RQ16
		##1 mac_done ##1 (s.st == ST_RUN))
		else $error("short multiply latency wrong");
	a_mac16_time: assert property (mac_start && (mac_op_c == MAC_ACC16) |->       // RQ17
		##1 !mac_done ##1 mac_done)
		else $error("short accumulate latency wrong");
	a_mac32_time: assert property (mac_start && (mac_op_c == MAC_ACC32) |->       // RQ18
		(!mac_done)[*3] ##1 mac_done ##1 ({s.mac_result_high, s.mac_result_low} == $past(mac_res)))
		else $error("long accumulate latency or result wrong");
	a_load_sext: assert property ((s.st == ST_MEM) && !s.we && !s.rmw && i_dmem_ack |=> // RQ7
		s.gpr[$past(s.ld_rn)] == $past(ld_ext))
		else $error("load not sign-extended into register");
endmodule : rce_core

// ==== verilog/rce_mac_unit.sv ====
// Multi-cycle multiplier and accumulator for the execution core
`timescale 1ns/1ps
`include "rce_map.svh"
module rce_mac_unit #(
	parameter int MUL16_CYC = `RCE_MUL16_CYC,
	parameter int MAC16_CYC = `RCE_MAC16_CYC,
	parameter int MAC32_CYC = `RCE_MAC32_CYC
) (
	// Clock and reset
	input  wire logic               i_sys_clk,
	input  wire logic               i_reset,
	// Operation request
	input  wire logic               i_start,
	input  rce_pkg::rce_macop_t     i_op,
	input  wire logic [31:0]        i_a,
	input  wire logic [31:0]        i_b,
	input  wire logic [63:0]        i_acc,
	// Result
	output logic                    o_done,
	output logic [63:0]             o_result
);
	import rce_pkg::*;
	rce_mac_st_t s, n;
	logic signed [63:0] p16;
	logic signed [63:0] p32;

	// Signed products of the low halves and of full words
	assign p16 = 64'($signed(i_a[15:0])) * 64'($signed(i_b[15:0]));
	assign p32 = 64'($signed(i_a)) * 64'($signed(i_b));

	// Result captured at start, then held for the op latency
	always_comb begin
		n = s;
		if (i_start) begin
			n.busy = 1'b1;
			case (i_op)
				MAC_MUL16: begin
					n.res = {i_acc[63:32], p16[31:0]};
					n.cnt = 3'(MUL16_CYC - 1);
				end
				MAC_ACC16: begin
					n.res = i_acc + p16;
					n.cnt = 3'(MAC16_CYC - 1);
				end
				default: begin
					n.res = i_acc + p32;
					n.cnt = 3'(MAC32_CYC - 1);
				end
			endcase
		end else if (s.busy) begin
			n.cnt = s.cnt - 3'h1;
			n.busy = (s.cnt != 3'h1);
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Done in the last wait cycle
	assign o_done   = s.busy && (s.cnt == 3'h1);
	assign o_result = s.res;
endmodule : rce_mac_unit

// ==== verilog/rce_map.svh ====
// Offsets, reset values, field positions and timing counts of the execution core
`ifndef RCE_MAP_SVH
`define RCE_MAP_SVH
// Vector table offsets from the vector base
`define RCE_VEC_PC_OFS      32'h00000000
`define RCE_VEC_SP_OFS      32'h00000004
`define RCE_VEC_ADDRERR_OFS 32'h00000024
// Status register layout and reset value
`define RCE_SR_T_BIT        0
`define RCE_SR_IMASK_LSB    4
`define RCE_SR_IMASK_MSB    7
`define RCE_SR_RESET        32'h000000f0
`define RCE_VBR_RESET       32'h00000000
// Instruction stride and stack slot size
`define RCE_INSTR_BYTES     32'h00000002
`define RCE_SLOT_BYTES      32'h00000004
// Multiplier latencies in clock cycles
`define RCE_MUL16_CYC       2
`define RCE_MAC16_CYC       3
`define RCE_MAC32_CYC       4
// Basic instruction time and clock rate
`define RCE_INSTR_NS        50
`define RCE_CLK_MHZ         20
`define RCE_INSTR_CYC       ((`RCE_INSTR_NS * `RCE_CLK_MHZ) / 1000)
`endif

// ==== verilog/rce_pkg.sv ====
// Types shared by the execution core and its multiplier
package rce_pkg;
	typedef enum logic [3:0] {
		ST_VEC_PC  = 4'h0, ST_VEC_SP  = 4'h1, ST_RUN     = 4'h3, ST_MEM     = 4'h2,
		ST_RMW_WR  = 4'h6, ST_MAC     = 4'h7, ST_PUSH_SR = 4'h5, ST_PUSH_PC = 4'h4,
		ST_EXC_VEC = 4'hc
	} rce_state_t;
	typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} rce_size_t;
	typedef enum logic [1:0] {MAC_MUL16 = 2'h0, MAC_ACC16 = 2'h1, MAC_ACC32 = 2'h2} rce_macop_t;
	typedef enum logic [3:0] {
		OP_MOVI = 4'h0, OP_ADDI = 4'h1, OP_CMPEQI = 4'h2, OP_ANDI = 4'h3,
		OP_ORI  = 4'h4, OP_XORI = 4'h5, OP_TSTI   = 4'h6, OP_REG  = 4'h7,
		OP_LDST = 4'h8, OP_LDPCW = 4'h9, OP_LDPCL = 4'ha, OP_BRA  = 4'hb,
		OP_BCOND = 4'hc, OP_BSR = 4'hd, OP_RTS    = 4'he, OP_BITMEM = 4'hf
	} rce_op_t;
	typedef enum logic [3:0] {
		FN_MOV = 4'h0, FN_ADD = 4'h1, FN_AND = 4'h2, FN_OR = 4'h3,
		FN_XOR = 4'h4, FN_CMPEQ = 4'h5, FN_CMPGE = 4'h6, FN_MUL16 = 4'h7,
		FN_MAC16 = 4'h8, FN_MAC32 = 4'h9, FN_STS_HI = 4'ha, FN_STS_LO = 4'hb,
		FN_STS_PR = 4'hc, FN_LDC_GB = 4'hd, FN_CLRMAC = 4'he, FN_STC_SR = 4'hf
	} rce_func_t;
	typedef struct packed {
		rce_state_t       st;
		logic [15:0][31:0] gpr;
		logic [31:0]      sr;
		logic [31:0]      global_base_reg;
		logic [31:0]      vector_base_reg;
		logic [31:0]      mac_result_high;
		logic [31:0]      mac_result_low;
		logic [31:0]      pr;
		logic [31:0]      pc;
		logic             br_pend;
		logic [31:0]      br_tgt;
		logic             req;
		logic             we;
		logic [31:0]      addr;
		rce_size_t        size;
		logic [31:0]      wdata;
		logic [3:0]       ld_rn;
		logic             rmw;
		logic [1:0]       rmw_op;
		logic [7:0]       rmw_imm;
		logic [31:0]      exc_pc;
		logic             addr_err;
		logic             retire;
	} rce_core_st_t;
	typedef struct packed {
		logic        busy;
		logic [2:0]  cnt;
		logic [63:0] res;
	} rce_mac_st_t;
endpackage : rce_pkg
